// *** inc/pmpf_pkg.sv ***
// Package for the mode and pin-function register bank.
// Assumes a 32-bit APB master and a single pclk domain.
package pmpf_pkg;

  // ----------------------------------------------------------------
  // Register indices and address/register widths
  // ----------------------------------------------------------------
  localparam logic [9:0]  IDX_PEAK_AB   = 10'h1A5;
  localparam logic [9:0]  IDX_PEAK_CD   = 10'h1A6;
  localparam logic [9:0]  IDX_OP_PATH   = 10'h1DF;
  localparam logic [9:0]  IDX_PIN_FUNC  = 10'h1E0;
  localparam int          ADDR_W        = 12;
  localparam int          REG_W         = 16;

  // ----------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_PEAK      = 16'h0000;
  localparam logic [15:0] RST_OP_PATH   = 16'h0040;
  localparam logic [15:0] RST_PIN_FUNC  = 16'h417A;
  localparam logic [15:0] OP_PATH_WMASK = 16'h0067;
  localparam int          PEAKS         = 5;
  localparam int          PEAK_W        = 2 * PEAKS;
  localparam int          OPC_LSB       = 0;
  localparam int          MII_BIT       = 5;
  localparam int          BRIDGE_BIT    = 6;
  localparam int          PIN0_LSB      = 0;
  localparam int          PIN1_LSB      = 4;

  // ----------------------------------------------------------------
  // Operating path codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PMPF_RGMII_COPPER, PMPF_RGMII_1000X, PMPF_RGMII_100FX, PMPF_RGMII_SGMII,
    PMPF_1000T_1000X, PMPF_100T_100FX, PMPF_SGMII_COPPER, PMPF_PATH_RSVD
  } pmpf_path_e;

  // ----------------------------------------------------------------
  // Pin function codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FN_CLK_OUT  = 4'h0;
  localparam logic [3:0] FN_INTR     = 4'h2;
  localparam logic [3:0] FN_LINK     = 4'h3;
  localparam logic [3:0] FN_TX_DELIM = 4'h5;
  localparam logic [3:0] FN_RX_DELIM = 4'h6;
  localparam logic [3:0] FN_WOL      = 4'h7;
  localparam logic [3:0] FN_ENERGY   = 4'h8;
  localparam logic [3:0] FN_PRBS     = 4'h9;
  localparam logic [3:0] FN_LED2     = 4'hA;
  localparam logic [3:0] FN_LED_GP   = 4'hB;
  localparam logic [3:0] FN_CRS      = 4'hC;
  localparam logic [3:0] FN_COL      = 4'hD;
  localparam logic [3:0] FN_LOW      = 4'hE;
  localparam logic [3:0] FN_HIGH     = 4'hF;

  // Signals that may be routed onto the multipurpose pins
  typedef struct packed {
    logic clk_out;
    logic interrupt;
    logic link_status;
    logic transmit_delimiter_flag;
    logic receive_delimiter_flag;
    logic wake_on_lan_output;
    logic energy_detect;
    logic prbs_error;
    logic second_led_output;
    logic led_general_output;
    logic carrier_sense;
    logic collision;
  } pmpf_src_s;

endpackage

// *** rtl/pmpf_regs.sv ***
// Mode and multipurpose pin-function register bank with APB slave.
// Assumes peak polarities and pin sources come from logic on pclk.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Register 0x1A5 is read-only, resets to zero, holds peak signs 0-4 of A then B, 15-10 zero.
// - Register 0x1A6 is read-only, resets to zero, holds peak signs 0-4 of C then D, upper zero.
// - Bits 2-0 of the mode register select one of seven data paths, code 7 reserved.
// - Mode bit 6 picks bridge direction and bit 5 picks RGMII or MII, both writable.
// - Mode register 0x1DF resets to 0x0040 and its reserved bits read zero.
// - Bits 3-0 of the pin-function register select what drives pin 0, reset to second LED.
// - Codes 0,2,3,5,6,7,8,9 select clock, interrupt, link, tx/receive_delimiter_flag, WoL, energy, PRBS.
// - With either SFD indication enabled, pin 0 carries the receive SFD flag.
// - Bits 7-4 select the function of pin 1 with the same code table.
// - With either SFD indication enabled, pin 1 carries the transmit SFD flag.
// - Register 0x1E0 resets to 0x417A and every bit of it is read/write.
module pmpf_regs (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      clk_en,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [13:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [pmpf_pkg::PEAK_W-1:0] peak_polarity_ab,
  input  wire logic [pmpf_pkg::PEAK_W-1:0] peak_polarity_cd,
  input  wire logic                      delimiter_enable,
  input  wire pmpf_pkg::pmpf_src_s       pin_sources,
  output var pmpf_pkg::pmpf_path_e       operation_path_code,
  output logic                           bridge_direction,
  output logic                           mii_select,
  output logic                           mpin0_out,
  output logic                           mpin1_out
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Index is the byte address divided by four; low two bits ignored
  function automatic logic [2:0] reg_hit(input logic [13:0] addr);
    logic [11:0] idx;
    idx = addr[13:2];
    reg_hit = 3'h4;
    if (idx == {2'h0, pmpf_pkg::IDX_PEAK_AB}) begin
      reg_hit = 3'h0;
    end else if (idx == {2'h0, pmpf_pkg::IDX_PEAK_CD}) begin
      reg_hit = 3'h1;
    end else if (idx == {2'h0, pmpf_pkg::IDX_OP_PATH}) begin
      reg_hit = 3'h2;
    end else if (idx == {2'h0, pmpf_pkg::IDX_PIN_FUNC}) begin
      reg_hit = 3'h3;
    end
  endfunction

  // Shared by both pins so the code table cannot drift between them
  function automatic logic pin_select(input logic [3:0] code,
                                      input pmpf_pkg::pmpf_src_s s);
    pin_select = 1'b0;
    case (code)
      pmpf_pkg::FN_CLK_OUT:  pin_select = s.clk_out;
      pmpf_pkg::FN_INTR:     pin_select = s.interrupt;
      pmpf_pkg::FN_LINK:     pin_select = s.link_status;
      pmpf_pkg::FN_TX_DELIM: pin_select = s.transmit_delimiter_flag;
      pmpf_pkg::FN_RX_DELIM: pin_select = s.receive_delimiter_flag;
      pmpf_pkg::FN_WOL:      pin_select = s.wake_on_lan_output;
      pmpf_pkg::FN_ENERGY:   pin_select = s.energy_detect;
      pmpf_pkg::FN_PRBS:     pin_select = s.prbs_error;
      pmpf_pkg::FN_LED2:     pin_select = s.second_led_output;
      pmpf_pkg::FN_LED_GP:   pin_select = s.led_general_output;
      pmpf_pkg::FN_CRS:      pin_select = s.carrier_sense;
      pmpf_pkg::FN_COL:      pin_select = s.collision;
      pmpf_pkg::FN_LOW:      pin_select = 1'b0;
      pmpf_pkg::FN_HIGH:     pin_select = 1'b1;
      default:               pin_select = 1'b0;
    endcase
  endfunction

  // Writable bits per register; read-only words give an all-zero mask
  function automatic logic [15:0] wr_mask(input logic [2:0] sel);
    wr_mask = 16'h0000;
    case (sel)
      3'h0:    wr_mask = 16'h0000;
      3'h1:    wr_mask = 16'h0000;
      3'h2:    wr_mask = pmpf_pkg::OP_PATH_WMASK;
      3'h3:    wr_mask = 16'hFFFF;
      default: wr_mask = 16'h0000;
    endcase
  endfunction

  // Keeps read-only bits and takes the writable ones from the bus
  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [15:0] new_v,
                                        input logic [15:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  localparam int CHANS = 4;

  logic [pmpf_pkg::PEAKS-1:0]    chan_sign_r [CHANS];
  logic [2*pmpf_pkg::PEAK_W-1:0] chan_in;
  logic [15:0]                   peak_ab;
  logic [15:0]                   peak_cd;
  logic [15:0] op_path_r;
  logic [15:0] pin_func_r;
  logic [2:0]  hit;
  logic        setup;
  logic        wr_take;
  logic [15:0] rd_nxt;

  assign hit     = reg_hit(paddr);
  assign setup   = psel & ~penable;
  // Write lands at the single edge where the master sees pready high
  assign wr_take = psel & penable & pready & pwrite;

  // ----------------------------------------------------------------
  // Peak signs
  // ----------------------------------------------------------------
  // Peak signs track the reflectometry engine; the bus cannot alter them
  // Channels A, B, C, D sit low field first in the two input words
  assign chan_in = {peak_polarity_cd, peak_polarity_ab};

  generate
    for (genvar g = 0; g < CHANS; g++) begin : g_chan
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          chan_sign_r[g] <= pmpf_pkg::RST_PEAK[pmpf_pkg::PEAKS-1:0];
        end else if (clk_en) begin
          chan_sign_r[g] <= chan_in[g*pmpf_pkg::PEAKS +: pmpf_pkg::PEAKS];
        end
      end
    end
  endgenerate

  // Reserved upper bits are tied low, never stored
  assign peak_ab = {6'h00, chan_sign_r[1], chan_sign_r[0]};
  assign peak_cd = {6'h00, chan_sign_r[3], chan_sign_r[2]};

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_path_r <= pmpf_pkg::RST_OP_PATH;
    end else if (clk_en && wr_take && hit == 3'h2) begin
      // Reserved bits are masked so they keep reading zero
      op_path_r <= merge(op_path_r, pwdata[15:0], wr_mask(hit));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_func_r <= pmpf_pkg::RST_PIN_FUNC;
    end else if (clk_en && wr_take && hit == 3'h3) begin
      pin_func_r <= merge(pin_func_r, pwdata[15:0], wr_mask(hit));
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  always_comb begin
    case (hit)
      3'h0:    rd_nxt = peak_ab;
      3'h1:    rd_nxt = peak_cd;
      3'h2:    rd_nxt = op_path_r;
      3'h3:    rd_nxt = pin_func_r;
      default: rd_nxt = 16'h0000;
    endcase
  end

  // Answer prepared in setup so every bus output is a flop; zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= setup;
    end
  end

  // Unmapped words answer with an error; writes to them are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pslverr <= setup & (hit == 3'h4);
    end
  end

  // Read data holds until the next read setup, so a slow master still sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      if (setup && !pwrite) begin
        prdata <= {16'h0000, rd_nxt};
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode outputs
  // ----------------------------------------------------------------
  // Reserved path code 7 is passed on as written; the data path ignores it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operation_path_code <= pmpf_pkg::PMPF_RGMII_COPPER;
    end else if (clk_en) begin
      operation_path_code <= pmpf_pkg::pmpf_path_e'(op_path_r[2:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bridge_direction <= 1'b1;
    end else if (clk_en) begin
      bridge_direction <= op_path_r[pmpf_pkg::BRIDGE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mii_select <= 1'b0;
    end else if (clk_en) begin
      mii_select <= op_path_r[pmpf_pkg::MII_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------
  logic [3:0] pin_code [2];
  logic       pin_ovr  [2];
  logic       pin_q    [2];

  assign pin_code[0] = pin_func_r[pmpf_pkg::PIN0_LSB +: 4];
  assign pin_code[1] = pin_func_r[pmpf_pkg::PIN1_LSB +: 4];
  assign pin_ovr[0]  = pin_sources.receive_delimiter_flag;
  assign pin_ovr[1]  = pin_sources.transmit_delimiter_flag;

  // SFD override wins over any programmed code, costing one flop of delay
  generate
    for (genvar p = 0; p < 2; p++) begin : g_pin
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_q[p] <= 1'b0;
        end else if (clk_en) begin
          if (delimiter_enable) begin
            pin_q[p] <= pin_ovr[p];
          end else begin
            pin_q[p] <= pin_select(pin_code[p], pin_sources);
          end
        end
      end
    end
  endgenerate

  assign mpin0_out = pin_q[0];
  assign mpin1_out = pin_q[1];

endmodule

`default_nettype wire

// *** sim/pmpf_regs_assertions.sv ***
// Checker for the mode and pin-function register bank.
// Assumes one pclk domain and zero-wait APB answers.
`timescale 1ns/1ps
`default_nettype none
module pmpf_regs_chk (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 clk_en,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [13:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 delimiter_enable,
  input wire pmpf_pkg::pmpf_src_s  pin_sources,
  input wire pmpf_pkg::pmpf_path_e operation_path_code,
  input wire logic                 bridge_direction,
  input wire logic                 mii_select,
  input wire logic                 mpin0_out,
  input wire logic                 mpin1_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [11:0] idx;
  logic        acc;
  assign idx = paddr[13:2];
  assign acc = psel && penable && pready;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  peak_upper_a: assert property (
    acc && !pwrite && (idx == 12'h1A5 || idx == 12'h1A6) |-> prdata[31:10] == 22'h0)
    else $error("peak register upper bits set");
  mode_rsvd_a: assert property (
    acc && !pwrite && idx == 12'h1DF |-> (prdata & 32'hFFFFFF98) == 32'h0)
    else $error("mode reserved bits set");
  path_follow_a: assert property (
    acc && clk_en && pwrite && idx == 12'h1DF ##1 clk_en |=>
    operation_path_code == $past(pwdata[2:0], 2) && bridge_direction == $past(pwdata[6], 2)
    && mii_select == $past(pwdata[5], 2)) else $error("mode outputs wrong");
  mode_reset_a: assert property (
    $rose(presetn) |-> bridge_direction && !mii_select && operation_path_code == 3'h0)
    else $error("mode reset value wrong");
  delim_route_a: assert property (
    delimiter_enable && clk_en |=> mpin0_out == $past(pin_sources.receive_delimiter_flag)
    && mpin1_out == $past(pin_sources.transmit_delimiter_flag)) else $error("override wrong");
  unmapped_err_a: assert property (
    acc |-> pslverr == !(idx == 12'h1A5 || idx == 12'h1A6 || idx == 12'h1DF || idx == 12'h1E0))
    else $error("pslverr wrong");
  pin0_const_a: assert property (
    acc && pwrite && idx == 12'h1E0 && pwdata[3:1] == 3'h7 ##1 clk_en && !delimiter_enable
    |=> mpin0_out == $past(pwdata[0], 2)) else $error("pin0 constant wrong");
  pin1_const_a: assert property (
    acc && pwrite && idx == 12'h1E0 && pwdata[7:5] == 3'h7 ##1 clk_en && !delimiter_enable
    |=> mpin1_out == $past(pwdata[4], 2)) else $error("pin1 constant wrong");
  cover property (acc && pslverr);
  cover property (acc && pwrite && idx == 12'h1DF);
  cover property (delimiter_enable && clk_en);
endmodule
bind pmpf_regs pmpf_regs_chk chk_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .delimiter_enable, .pin_sources,
  .operation_path_code, .bridge_direction, .mii_select, .mpin0_out, .mpin1_out);
`default_nettype wire

// *** sim/pmpf_regs_test.sv ***
// Self-checking bench for the register bank.
// Assumes pmpf_pkg and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pmpf_regs_test;
  logic                 pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic                 delim_en, brd, mii, m0, m1;
  logic [13:0]          paddr;
  logic [31:0]          pwdata, prdata, pk;
  logic [15:0]          sr, r, lf;
  logic [1:0]           e;
  pmpf_pkg::pmpf_path_e opc;
  logic [32:0]          q[$];
  int                   error_cnt, n_checks;
  pmpf_regs dut_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .peak_polarity_ab(pk[9:0]), .peak_polarity_cd(pk[25:16]),
    .delimiter_enable(delim_en), .pin_sources(sr[11:0]), .operation_path_code(opc),
    .bridge_direction(brd), .mii_select(mii), .mpin0_out(m0), .mpin1_out(m1));
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  // Expected pin level per code; reserved codes 1 and 4 give low
  function automatic logic fn(logic [3:0] c, pmpf_pkg::pmpf_src_s s);
    logic [15:0] t;
    t = {2'b10, s.collision, s.carrier_sense, s.led_general_output, s.second_led_output,
      s.prbs_error, s.energy_detect, s.wake_on_lan_output, s.receive_delimiter_flag,
      s.transmit_delimiter_flag, 1'b0, s.link_status, s.interrupt, 1'b0, s.clk_out};
    return t[c];
  endfunction
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Reads note their expected {pslverr, prdata} for the monitor
  task automatic apb(input logic [9:0] i, input logic w, input logic [15:0] d,
                     input logic [32:0] x);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= {2'h0, i, 2'h0};
    pwrite <= w;
    pwdata <= {rnd(), d};
    if (!w) q.push_back(x);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic test_done();
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, q.pop_front());
  end
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    test_done();
  end
  initial begin
    lf = 16'h43EC;
    {presetn, clk_en, psel, penable, pwrite, paddr, pwdata, delim_en} = '0;
    clk_en = 1'b1;
    pk = {rnd(), rnd()};
    sr = rnd();
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(10'h1A5, 1'b0, 16'h0, {23'h0, pk[9:0]});
    apb(10'h1A6, 1'b0, 16'h0, {23'h0, pk[25:16]});
    apb(10'h1DF, 1'b0, 16'h0, 33'h40);
    apb(10'h1E0, 1'b0, 16'h0, 33'h417A);
    apb(10'h1C0, 1'b1, 16'hFFFF, 33'h0);
    apb(10'h1C0, 1'b0, 16'h0, 33'h100000000);
    chk({m0, m1}, {fn(4'hA, sr[11:0]), fn(4'h7, sr[11:0])});
    for (int k = 0; k < 3; k++) apb(10'h1A5 + k[9:0], 1'b1, 16'hFFFF, 33'h0);
    apb(10'h1A6, 1'b0, 16'h0, {23'h0, pk[25:16]});
    apb(10'h1DF, 1'b1, 16'hFFFF, 33'h0);
    apb(10'h1DF, 1'b0, 16'h0, 33'h67);
    for (int c = 0; c < 8; c++) begin
      apb(10'h1DF, 1'b1, {9'h0, c[0], c[1], 2'h0, c[2:0]}, 33'h0);
      repeat (2) @(posedge pclk);
      #1 chk({opc, brd, mii}, {c[2:0], c[0], c[1]});
    end
    // Codes and sources change together; reserved nibbles take random data
    for (int c = 0; c < 16; c++) begin
      r = rnd();
      sr <= rnd();
      apb(10'h1E0, 1'b1, {r[15:8], ~c[3:0], c[3:0]}, 33'h0);
      apb(10'h1E0, 1'b0, 16'h0, {17'h0, r[15:8], ~c[3:0], c[3:0]});
      #1 chk({m0, m1}, {fn(c[3:0], sr[11:0]), fn(~c[3:0], sr[11:0])});
    end
    delim_en <= 1'b1;
    sr <= rnd();
    repeat (2) @(posedge pclk);
    e = {fn(4'h6, sr[11:0]), fn(4'h5, sr[11:0])};
    #1 chk({m0, m1}, e);
    // Clock enable low must hold the pins even as sources move
    clk_en <= 1'b0;
    sr <= ~sr;
    repeat (2) @(posedge pclk);
    #1 chk({m0, m1}, e);
    clk_en <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(q.size(), 33'h0);
    test_done();
  end
endmodule
`default_nettype wire
